// ### socket_ctrl_pkg.sv
// Constants for the socket strap, power switch and sense/strobe block
package socket_ctrl_pkg;
    // Host port select: index port or data port
    localparam logic IO_ADDR_INDEX = 1'b0;
    localparam logic IO_ADDR_DATA = 1'b1;
    localparam int SLOTS = 2;
    // Index fields
    localparam int IDX_REGION_BIT = 7;
    localparam int IDX_SLOT_BIT = 6;
    localparam int IDX_OFF_MSB = 5;
    // Per-slot register offsets within a 64-entry socket space
    localparam logic [5:0] OFF_POWER = 6'h02;
    localparam logic [5:0] OFF_EXT_INDEX = 6'h2E;
    localparam logic [5:0] OFF_EXT_DATA = 6'h2F;
    // Extended register indices
    localparam logic [7:0] EXT_SENSE_DATA = 8'h0A;
    localparam logic [7:0] EXT_CTRL_TWO = 8'h0B;
    // Power register fields
    localparam int PWR_VPP_LSB = 0;
    localparam int PWR_VCC_ON_BIT = 4;
    localparam int PWR_VCC_3V3_BIT = 5;
    localparam logic [1:0] VPP_OFF = 2'h0;
    localparam logic [1:0] VPP_FROM_VCC = 2'h1;
    localparam logic [1:0] VPP_PROGRAM = 2'h2;
    // Extension control two: strobe drive bit
    localparam int CTL2_STROBE_BIT = 0;
    // External sense data fields
    localparam int SENSE_ONE_BIT = 0;
    localparam int SENSE_TWO_BIT = 1;
    // Values after reset, and the socket numbers used for a high and a low strap
    localparam logic STRAP_RESET = 1'b1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] SOCKET_FIRST_HIGH = 2'h0;
    localparam logic [1:0] SOCKET_SECOND_HIGH = 2'h1;
    localparam logic [1:0] SOCKET_FIRST_LOW = 2'h2;
    localparam logic [1:0] SOCKET_SECOND_LOW = 2'h3;
endpackage

// ### regbank_if.sv
// Carrier between the index decoder and one slot's register bank
`timescale 1ns/100ps
interface regbank_if;
    logic wr;
    logic [5:0] offset;
    logic [7:0] wdata;
    logic [7:0] sense;
    logic [7:0] rdata;
    logic [7:0] ext_ctl2;
    logic [7:0] power;
    modport host (output wr, output offset, output wdata, output sense,
        input rdata, input ext_ctl2, input power);
    modport bank (input wr, input offset, input wdata, input sense,
        output rdata, output ext_ctl2, output power);
endinterface

// ### slot_regbank.sv
// Register bank of one socket slot: power control, extended index and data
`timescale 1ns/100ps
module slot_regbank (
    input wire logic ref_clk,
    input wire logic rst,
    regbank_if.bank rb
);
    logic [7:0] ext_index_r;
    logic [7:0] ext_ctl2_r;
    logic [7:0] power_r;
    wire wr_power = rb.wr && (rb.offset == socket_ctrl_pkg::OFF_POWER);
    wire wr_ext_index = rb.wr && (rb.offset == socket_ctrl_pkg::OFF_EXT_INDEX);
    wire ext_data_hit = rb.offset == socket_ctrl_pkg::OFF_EXT_DATA;
    wire ext_is_ctl2 = ext_index_r == socket_ctrl_pkg::EXT_CTRL_TWO;
    wire ext_is_sense = ext_index_r == socket_ctrl_pkg::EXT_SENSE_DATA;
    wire wr_ctl2 = rb.wr && ext_data_hit && ext_is_ctl2;
    wire [7:0] ext_rdata = ext_is_ctl2 ? ext_ctl2_r :
        (ext_is_sense ? rb.sense : 8'h00);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_index_r <= socket_ctrl_pkg::REG_RESET;
            ext_ctl2_r <= socket_ctrl_pkg::REG_RESET;
            power_r <= socket_ctrl_pkg::REG_RESET;
        end else begin
            if (wr_ext_index) begin
                ext_index_r <= rb.wdata;
            end
            if (wr_ctl2) begin
                ext_ctl2_r <= rb.wdata;
            end
            if (wr_power) begin
                power_r <= rb.wdata;
            end
        end
    end

    assign rb.rdata = (rb.offset == socket_ctrl_pkg::OFF_POWER) ? power_r :
        (rb.offset == socket_ctrl_pkg::OFF_EXT_INDEX) ? ext_index_r :
        ext_data_hit ? ext_rdata : 8'h00;
    assign rb.ext_ctl2 = ext_ctl2_r;
    assign rb.power = power_r;
endmodule

// ### socket_strap_power_sense_ctrl.sv
// Socket strap latch, card power switch outputs and sense/strobe registers
`timescale 1ns/100ps
module socket_strap_power_sense_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic power_good_in,
    input wire logic socket_select_strap,
    output logic strap_pullup_en,
    input wire logic io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic [1:0] socket_first_num,
    output logic [1:0] socket_second_num,
    input wire logic voltage_sense_one,
    input wire logic voltage_sense_two,
    output logic gp_strobe_first_out,
    output logic gp_strobe_first_oe,
    output logic gp_strobe_second_out,
    output logic gp_strobe_second_oe,
    output logic [1:0] vpp_from_vcc_en,
    output logic [1:0] vpp_program_supply_en,
    output logic [1:0] card_3v3_en_n,
    output logic [1:0] card_5v_en_n
);
    // Index belongs to this device when its region bit is the inverse of the strap
    function automatic logic index_hit(input logic [7:0] idx, input logic strap);
        index_hit = idx[socket_ctrl_pkg::IDX_REGION_BIT] == ~strap;
    endfunction

    logic power_good_prev_r;
    logic strap_r;
    logic strap_pullup_r;
    logic [7:0] index_r;
    logic [7:0] rdata_r;
    logic [1:0] first_num_r;
    logic [1:0] second_num_r;
    logic [1:0] strobe_oe_r;
    logic [1:0] strobe_out_r;
    logic [1:0] vpp_vcc_r;
    logic [1:0] vpp_program_supply_en_r;
    logic [1:0] vcc3_n_r;
    logic [1:0] vcc5_n_r;
    logic [7:0] slot_rdata [socket_ctrl_pkg::SLOTS];

    regbank_if rb [socket_ctrl_pkg::SLOTS] ();

    wire power_good_rise = power_good_in && !power_good_prev_r;
    wire at_index_port = io_addr == socket_ctrl_pkg::IO_ADDR_INDEX;
    wire at_data_port = io_addr == socket_ctrl_pkg::IO_ADDR_DATA;
    wire hit = index_hit(index_r, strap_r);
    wire slot_sel = index_r[socket_ctrl_pkg::IDX_SLOT_BIT];
    wire [5:0] slot_offset = index_r[socket_ctrl_pkg::IDX_OFF_MSB:0];
    wire data_wr = io_wr && at_data_port && hit;
    wire [7:0] sense_byte = {6'h00, voltage_sense_two, voltage_sense_one};
    wire [7:0] data_rdata = hit ? slot_rdata[slot_sel] : 8'h00;
    wire [7:0] port_rdata = at_index_port ? index_r : data_rdata;
    wire [1:0] first_num_nxt = strap_r ? socket_ctrl_pkg::SOCKET_FIRST_HIGH :
        socket_ctrl_pkg::SOCKET_FIRST_LOW;
    wire [1:0] second_num_nxt = strap_r ? socket_ctrl_pkg::SOCKET_SECOND_HIGH :
        socket_ctrl_pkg::SOCKET_SECOND_LOW;

    // Strap capture and reset-time pull-up
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_good_prev_r <= 1'b0;
            strap_r <= socket_ctrl_pkg::STRAP_RESET;
            strap_pullup_r <= 1'b1;
        end else begin
            power_good_prev_r <= power_good_in;
            strap_pullup_r <= 1'b0;
            if (power_good_rise) begin
                strap_r <= socket_select_strap;
            end
        end
    end

    // Index port and registered read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            index_r <= socket_ctrl_pkg::REG_RESET;
            rdata_r <= socket_ctrl_pkg::REG_RESET;
            first_num_r <= socket_ctrl_pkg::SOCKET_FIRST_HIGH;
            second_num_r <= socket_ctrl_pkg::SOCKET_SECOND_HIGH;
        end else begin
            if (io_wr && at_index_port) begin
                index_r <= io_wdata;
            end
            if (io_rd) begin
                rdata_r <= port_rdata;
            end
            first_num_r <= first_num_nxt;
            second_num_r <= second_num_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < socket_ctrl_pkg::SLOTS; g++) begin : g_slot
            wire [1:0] vpp_sel = rb[g].power[socket_ctrl_pkg::PWR_VPP_LSB +: 2];
            wire vcc_on = rb[g].power[socket_ctrl_pkg::PWR_VCC_ON_BIT];
            wire vcc_3v3 = rb[g].power[socket_ctrl_pkg::PWR_VCC_3V3_BIT];
            // One decoded code drives at most one of the two VPP switches
            wire vpp_vcc_nxt = vpp_sel == socket_ctrl_pkg::VPP_FROM_VCC;
            wire vpp_program_supply_en_nxt = vpp_sel == socket_ctrl_pkg::VPP_PROGRAM;
            wire vcc3_n_nxt = !(vcc_on && vcc_3v3);
            wire vcc5_n_nxt = !(vcc_on && !vcc_3v3);
            wire strobe_nxt = rb[g].ext_ctl2[socket_ctrl_pkg::CTL2_STROBE_BIT];

            assign rb[g].wr = data_wr && (slot_sel == 1'(g));
            assign rb[g].offset = slot_offset;
            assign rb[g].wdata = io_wdata;
            // Sense levels appear only in the second slot's space
            assign rb[g].sense = (g == 1) ? sense_byte : 8'h00;
            assign slot_rdata[g] = rb[g].rdata;

            slot_regbank u_bank (
                .ref_clk(ref_clk),
                .rst(rst),
                .rb(rb[g])
            );

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    vpp_vcc_r[g] <= 1'b0;
                    vpp_program_supply_en_r[g] <= 1'b0;
                    vcc3_n_r[g] <= 1'b1;
                    vcc5_n_r[g] <= 1'b1;
                    strobe_oe_r[g] <= 1'b0;
                    strobe_out_r[g] <= 1'b0;
                end else begin
                    vpp_vcc_r[g] <= vpp_vcc_nxt;
                    vpp_program_supply_en_r[g] <= vpp_program_supply_en_nxt;
                    vcc3_n_r[g] <= vcc3_n_nxt;
                    vcc5_n_r[g] <= vcc5_n_nxt;
                    // Open drain: pull low while the strobe bit is set
                    strobe_oe_r[g] <= strobe_nxt;
                    strobe_out_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign strap_pullup_en = strap_pullup_r;
    assign io_rdata = rdata_r;
    assign socket_first_num = first_num_r;
    assign socket_second_num = second_num_r;
    assign gp_strobe_first_out = strobe_out_r[0];
    assign gp_strobe_first_oe = strobe_oe_r[0];
    assign gp_strobe_second_out = strobe_out_r[1];
    assign gp_strobe_second_oe = strobe_oe_r[1];
    assign vpp_from_vcc_en = vpp_vcc_r;
    assign vpp_program_supply_en = vpp_program_supply_en_r;
    assign card_3v3_en_n = vcc3_n_r;
    assign card_5v_en_n = vcc5_n_r;
endmodule

// ### socket_ctrl_assertions.sv
// Assertions on the ports of the strap, power switch and strobe block
`timescale 1ns/100ps
module socket_ctrl_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic power_good_in,
    input wire logic socket_select_strap,
    input wire logic strap_pullup_en,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic [1:0] socket_first_num,
    input wire logic [1:0] socket_second_num,
    input wire logic [1:0] vpp_from_vcc_en,
    input wire logic [1:0] vpp_program_supply_en,
    input wire logic [1:0] card_3v3_en_n,
    input wire logic [1:0] card_5v_en_n,
    input wire logic gp_strobe_first_out,
    input wire logic gp_strobe_second_out
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_PULLUP: assert property (disable iff (1'b0) rst |=> strap_pullup_en)
        else $error("strap pull-up off in reset");
    AST_OFF_AT_RESET: assert property (disable iff (1'b0) rst |=>
        vpp_from_vcc_en == 2'h0 && card_5v_en_n == 2'h3) else $error("supplies on after reset");
    AST_VPP_EXCL: assert property ((vpp_from_vcc_en & vpp_program_supply_en) == 2'h0)
        else $error("both VPP switches on");
    AST_VCC_EXCL: assert property ((card_3v3_en_n | card_5v_en_n) == 2'h3)
        else $error("both card supplies on");
    AST_LATCH: assert property (power_good_in && !$past(power_good_in) |-> ##2
        socket_first_num == ($past(socket_select_strap, 2) ? 2'h0 : 2'h2))
        else $error("socket number not taken from strap");
    AST_PAIR: assert property (socket_second_num == socket_first_num + 2'h1)
        else $error("second socket number mismatch");
    AST_HOLD: assert property ($changed(socket_first_num) |-> $past(rst) || $past(rst, 2)
        || $past(rst, 3) || ($past(power_good_in, 2) && !$past(power_good_in, 3)))
        else $error("socket number changed without power-good edge");
    AST_RDATA_HOLD: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data changed without read");
    // Open-drain strobes only ever pull low
    AST_STROBE_LOW: assert property (!gp_strobe_first_out && !gp_strobe_second_out)
        else $error("strobe pin driven high");
    cover property (socket_first_num == 2'h2);
    cover property ($rose(vpp_program_supply_en[0]));
    cover property (card_3v3_en_n != 2'h3);
endmodule
bind socket_strap_power_sense_ctrl socket_ctrl_assertions chk (.ref_clk(ref_clk), .rst(rst),
    .power_good_in(power_good_in), .socket_select_strap(socket_select_strap),
    .strap_pullup_en(strap_pullup_en), .io_rd(io_rd), .io_rdata(io_rdata),
    .socket_first_num(socket_first_num), .socket_second_num(socket_second_num),
    .vpp_from_vcc_en(vpp_from_vcc_en), .vpp_program_supply_en(vpp_program_supply_en),
    .card_3v3_en_n(card_3v3_en_n), .card_5v_en_n(card_5v_en_n),
    .gp_strobe_first_out(gp_strobe_first_out), .gp_strobe_second_out(gp_strobe_second_out));

// ### card_socket_model.sv
// Card socket model: sense pins pulled up, grounded by the card key
`timescale 1ns/100ps
module card_socket_model (
    input wire logic [1:0] sense_key,
    output logic voltage_sense_one,
    output logic voltage_sense_two
);
    assign voltage_sense_one = ~sense_key[0];
    assign voltage_sense_two = ~sense_key[1];
endmodule

// ### socket_strap_power_sense_ctrl_tb.sv
// Self-checking bench for the strap, power switch and strobe block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module socket_strap_power_sense_ctrl_tb;
    logic ref_clk, rst = 1'b1, power_good_in = 1'b0, socket_select_strap = 1'b1;
    logic io_addr = 1'b0, io_wr = 1'b0, io_rd = 1'b0, strap_pullup_en, vs_one, vs_two;
    logic [7:0] io_wdata = 8'h00, io_rdata, rd_v;
    logic [1:0] sense_key = 2'h0, socket_first_num, socket_second_num;
    logic gp_strobe_first_out, gp_strobe_first_oe, gp_strobe_second_out, gp_strobe_second_oe;
    logic [1:0] vpp_from_vcc_en, vpp_program_supply_en, card_3v3_en_n, card_5v_en_n;
    int fails = 0, checks = 0;
    socket_strap_power_sense_ctrl dut (.ref_clk(ref_clk), .rst(rst),
        .power_good_in(power_good_in), .socket_select_strap(socket_select_strap),
        .strap_pullup_en(strap_pullup_en), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .socket_first_num(socket_first_num),
        .socket_second_num(socket_second_num), .voltage_sense_one(vs_one),
        .voltage_sense_two(vs_two), .gp_strobe_first_out(gp_strobe_first_out),
        .gp_strobe_first_oe(gp_strobe_first_oe), .gp_strobe_second_out(gp_strobe_second_out),
        .gp_strobe_second_oe(gp_strobe_second_oe), .vpp_from_vcc_en(vpp_from_vcc_en),
        .vpp_program_supply_en(vpp_program_supply_en), .card_3v3_en_n(card_3v3_en_n),
        .card_5v_en_n(card_5v_en_n));
    card_socket_model sock (.sense_key(sense_key), .voltage_sense_one(vs_one),
        .voltage_sense_two(vs_two));
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
    endtask
    task automatic ext(input logic [7:0] base, input logic [7:0] x);
        wr(1'b0, base | 8'h2E);
        wr(1'b1, x);
        wr(1'b0, base | 8'h2F);
    endtask
    task automatic ext_wr(input logic [7:0] base, input logic [7:0] x, input logic [7:0] d);
        ext(base, x);
        wr(1'b1, d);
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic ext_rd(input logic [7:0] base, input logic [7:0] x);
        ext(base, x);
        @(negedge ref_clk);
        io_addr = 1'b1;
        io_rd = 1'b1;
        @(negedge ref_clk);
        io_rd = 1'b0;
        rd_v = io_rdata;
    endtask
    task automatic pg_up(input logic s);
        @(negedge ref_clk);
        socket_select_strap = s;
        power_good_in = 1'b0;
        @(negedge ref_clk);
        power_good_in = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic t_reset;
        repeat (2) @(negedge ref_clk);
        `CHK("pullup", 1'b1, strap_pullup_en);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK("pullup", 1'b0, strap_pullup_en);
        `CHK("second socket", 2'h1, socket_second_num);
    endtask
    task automatic t_strap;
        pg_up(1'b0);
        `CHK("first socket", 2'h2, socket_first_num);
        `CHK("second socket", 2'h3, socket_second_num);
        socket_select_strap = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK("held socket", 2'h2, socket_first_num);
        ext_wr(8'hC0, 8'h0B, 8'h01);
        `CHK("strobe two", 1'b1, gp_strobe_second_oe);
        `CHK("strobe two out", 1'b0, gp_strobe_second_out);
        ext_wr(8'h80, 8'h0B, 8'h01);
        `CHK("strobe one", 1'b1, gp_strobe_first_oe);
        `CHK("strobe one out", 1'b0, gp_strobe_first_out);
        ext_rd(8'h80, 8'h0B);
        `CHK("control two", 8'h01, rd_v);
        ext_wr(8'h00, 8'h0B, 8'h00);
        `CHK("refused strobe", 1'b1, gp_strobe_first_oe);
        pg_up(1'b1);
        `CHK("first socket", 2'h0, socket_first_num);
        ext_wr(8'h80, 8'h0B, 8'h00);
        `CHK("refused strobe", 1'b1, gp_strobe_first_oe);
        ext_wr(8'h00, 8'h0B, 8'h00);
        `CHK("strobe one", 1'b0, gp_strobe_first_oe);
        ext_wr(8'h40, 8'h0B, 8'h00);
        `CHK("strobe two", 1'b0, gp_strobe_second_oe);
    endtask
    task automatic t_sense;
        for (int k = 0; k < 4; k++) begin
            sense_key = 2'(k);
            ext_rd(8'h40, 8'h0A);
            `CHK("sense data", ({6'h00, ~sense_key}), rd_v);
        end
        ext_rd(8'h00, 8'h0A);
        `CHK("first slot sense", 8'h00, rd_v);
    endtask
    task automatic t_rerun;
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK("pullup", 1'b1, strap_pullup_en);
        `CHK("vpp program", 2'h0, vpp_program_supply_en);
        `CHK("vcc 5v n", 2'h3, card_5v_en_n);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK("pullup", 1'b0, strap_pullup_en);
        `CHK("first socket", 2'h0, socket_first_num);
        `CHK("vpp program", 2'h0, vpp_program_supply_en);
    endtask
    task automatic t_power;
        wr(1'b0, 8'h02);
        wr(1'b1, 8'h31);
        repeat (2) @(negedge ref_clk);
        `CHK("vpp from vcc", 2'h1, vpp_from_vcc_en);
        `CHK("vcc 3v3 n", 2'h2, card_3v3_en_n);
        `CHK("vcc 5v n", 2'h3, card_5v_en_n);
        wr(1'b1, 8'h12);
        repeat (2) @(negedge ref_clk);
        `CHK("vpp program", 2'h1, vpp_program_supply_en);
        `CHK("vpp from vcc", 2'h0, vpp_from_vcc_en);
        `CHK("vcc 3v3 n", 2'h3, card_3v3_en_n);
        `CHK("vcc 5v n", 2'h2, card_5v_en_n);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        t_reset();
        t_strap();
        t_sense();
        t_power();
        t_rerun();
        complete_run();
    end
    initial begin
        #20000;
        fails++;
        complete_run();
    end
endmodule
